// *** sim/drbd_row_bank.sv ***
// partner model: dram rows that count the accesses steered to them
`timescale 1ns/1ps
module drbd_row_bank (
   input wire logic clk_sys,
   input wire logic [7:0] row_sel,
   input wire logic sel_valid,
   output int unsigned n_hits
);
   // rows only take a select strobe, they never answer back
   initial n_hits = 0;
   // count every cycle in which some row is selected
   always @(posedge clk_sys) begin
      if (sel_valid && row_sel != 8'h00) n_hits <= n_hits + 1;
   end
endmodule : drbd_row_bank

// *** sim/testbench.sv ***
// testbench: row limit registers and row decode, both device variants
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 1'b0; // 40 mhz controller clock
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic acc_valid = 1'b0;
   logic [35:0] acc_addr = 36'h0;
   logic [15:0] rd8, rd4; // read data, eight- and four-row parts
   logic v8, h8, v4, h4;
   logic [2:0] r8, r4;
   logic [7:0] s8, s4;
   int unsigned bank_hits;
   int n_errors = 0, checks = 0, cyc = 0, exp_hits = 0, t;
   logic [31:0] seed = 32'h3181;
   logic [10:0] lim [8]; // limits as software last wrote them
   drbd_row_decode dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rd8),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .dec_valid(v8), .dec_hit(h8),
      .dec_row(r8), .dec_row_sel(s8));
   drbd_row_decode #(.VARIANT(drbd_pkg::DRBD_VAR_FOUR)) dut4_u (.clk_sys(clk_sys),
      .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(rd4), .acc_valid(acc_valid), .acc_addr(acc_addr),
      .dec_valid(v4), .dec_hit(h4), .dec_row(r4), .dec_row_sel(s4));
   drbd_row_bank bank_u (.clk_sys(clk_sys), .row_sel(s8), .sel_valid(v8), .n_hits(bank_hits));
   // clock and hang guard
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         close_out();
      end
   end
   task close_out;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // lfsr step for repeatable random stimulus
   function automatic logic [31:0] next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next
   // lowest row whose limit lies above the address unit wins: {hit, row, sel}
   function automatic logic [11:0] expect_dec(logic [35:0] a, int nr, logic [10:0] m);
      logic [11:0] r;
      r = 12'h000;
      for (int i = nr - 1; i >= 0; i--) begin
         if ((a >> 22) < 36'(lim[i] & m)) r = {1'b1, 3'(i), 8'h01 << i};
      end
      return r;
   endfunction : expect_dec
   task wr(logic [7:0] a, logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic wrl(int i, logic [15:0] d);
      wr(8'h60 + 8'(2 * i), d);
      lim[i] = d[10:0];
   endtask : wrl
   // read data is looked at only in the cycle after the strobe
   task rd(logic [7:0] a, logic [15:0] e8, logic [15:0] e4);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk("rdata8", rd8, e8);
      chk("rdata4", rd4, e4);
   endtask : rd
   // write then read of one register with no gap between the strobes
   task wrrd(int i, logic [15:0] d, logic [15:0] e8, logic [15:0] e4);
      @(posedge clk_sys);
      reg_addr <= 8'h60 + 8'(2 * i);
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      lim[i] = d[10:0];
      chk("wrrd8", rd8, e8);
      chk("wrrd4", rd4, e4);
   endtask : wrrd
   task dec(logic [35:0] a);
      logic [11:0] e8, e4;
      e8 = expect_dec(a, 8, 11'h7ff);
      e4 = expect_dec(a, 4, 11'h07f);
      @(posedge clk_sys);
      acc_valid <= 1'b1;
      acc_addr <= a;
      @(posedge clk_sys);
      acc_valid <= 1'b0;
      @(negedge clk_sys);
      chk("valid8", 16'(v8), 16'h0001);
      chk("dec8", 16'({h8, r8, s8}), 16'(e8));
      chk("valid4", 16'(v4), 16'h0001);
      chk("dec4", 16'({h4, r4, s4}), 16'(e4));
      exp_hits += int'(e8[11]);
   endtask : dec
   initial begin
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // reset values of every limit register
      for (int i = 0; i < 8; i++) begin
         lim[i] = 11'h001;
         rd(8'h60 + 8'(2 * i), 16'h0001, 16'h0001);
      end
      dec(36'h0);
      dec(36'h400000);
      // field widths, reserved bits read zero, unmapped places refuse
      wrl(0, 16'hffff);
      rd(8'h60, 16'h07ff, 16'h007f);
      wr(8'h70, 16'h1234);
      rd(8'h70, 16'h0000, 16'h0000);
      rd(8'h61, 16'h0000, 16'h0000);
      wrrd(3, 16'hf0a5, 16'h00a5, 16'h0025);
      dec(36'h7fe << 22);
      dec(36'h7ff << 22);
      // empty row one gets the previous limit, rows past two copy limit two
      wrl(0, 16'h0004);
      wrl(1, 16'h0004);
      for (int i = 2; i < 8; i++) wrl(i, 16'h000c);
      dec(36'h0ffffff);
      dec(36'h1000000);
      dec(36'h2ffffff);
      dec(36'h3000000);
      dec(36'h800000000);
      // two-way rows of 256 mbytes each, then four-way rows of 512 mbytes each
      for (int i = 0; i < 8; i++) wrl(i, 16'(64 * (i + 1)));
      dec(36'h0c0 << 22);
      dec(36'h1ff << 22);
      for (int i = 0; i < 8; i++) wrl(i, 16'(128 * (i + 1)));
      dec(36'h080 << 22);
      dec(36'h3ff << 22);
      dec(36'h400 << 22);
      // random cumulative limits, sizes from empty up to 60 mbytes
      repeat (40) begin
         t = 0;
         for (int i = 0; i < 8; i++) begin
            seed = next(seed);
            t += int'(seed[3:0]);
            wrl(i, 16'(t));
         end
         repeat (6) begin
            seed = next(seed);
            dec(36'(seed[28:0]));
         end
      end
      // second reset in mid-run brings the default back
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(8'h66, 16'h0001, 16'h0001);
      @(negedge clk_sys);
      chk("bank hits", 16'(bank_hits), 16'(exp_hits));
      close_out();
   end
endmodule : testbench

// *** verilog/drbd_pkg.sv ***
// package: constants and types for the dram row boundary decode block
package drbd_pkg;
   // register geometry
   localparam int unsigned REG_W = 16;            // every row limit register is 16 bits wide
   localparam int unsigned MAX_ROWS = 8;          // largest variant decodes eight rows
   localparam int unsigned ROWS_SMALL = 4;        // smaller variant decodes four rows
   localparam int unsigned LIMIT_W_SMALL = 7;     // limit field 6:0 on four-row variant
   localparam int unsigned LIMIT_W_LARGE = 11;    // limit field 10:0 on eight-row variant
   localparam int unsigned UNIT_SHIFT = 22;       // 4 Mbyte granularity, 2^22 bytes
   localparam int unsigned ADDR_W = 36;           // controller-relative byte address width
   localparam int unsigned BUS_ADDR_W = 8;        // register port address width
   // printed offsets 60h..6fh: two bytes per register, word index = (offset-60h)/2
   localparam logic [7:0] ROW_LIMIT_BASE = 8'h60; // first row limit register offset
   localparam logic [7:0] ROW_LIMIT_STEP = 8'h02; // byte spacing of row limit registers
   // reset value of every limit register: one unit in row zero
   localparam logic [15:0] ROW_LIMIT_RST = 16'h0001;
   // variant select encodings
   typedef enum logic [0:0] {
      DRBD_VAR_FOUR = 1'b0,
      DRBD_VAR_EIGHT = 1'b1
   } drbd_variant_t;
endpackage : drbd_pkg

// *** verilog/drbd_row_cmp.sv ***
// module: one row boundary comparator, upper limit above address
`timescale 1ns/1ps
module drbd_row_cmp #(
   parameter int unsigned LIMIT_W = 11  // width of the limit field compared
) (
   input wire logic [LIMIT_W-1:0] limit,     // cumulative upper limit in units
   input wire logic [LIMIT_W-1:0] addr_unit, // access address in units
   input wire logic addr_over,                // address bits above the field are set
   output logic below                          // address lies under this limit
);
   // an address whose high bits overflow the field is never below any limit
   always_comb begin
      below = !addr_over && (addr_unit < limit); // [RQ5]
   end
endmodule : drbd_row_cmp

// *** verilog/drbd_row_decode.sv ***
// module: row limit registers and the access-to-row decoder
`timescale 1ns/1ps
//
// Contract
// RQ1: four-row variant decodes rows zero to three
// RQ2: eight-row variant decodes rows zero to seven
// RQ3: limit registers 16 bits, 4 Mbyte units
// RQ4: compare gap-free controller address, not physical
// RQ5: row bounded by own and previous limit
// RQ6: row size is limit minus previous limit
// RQ7: software gives empty rows previous limit
// RQ8: all limit registers reset to 0001h
// RQ9: software copies limit three into four-seven
// RQ10: four-row limit field 6:0, rest reserved
// RQ11: eight-row limit field 10:0, rest reserved
// RQ12: software keeps plain rows 4-128 Mbytes
// RQ13: software keeps two-way rows 8-256 Mbytes
// RQ14: software keeps four-way rows 16-512 Mbytes
// RQ15: lowest row whose limit exceeds address wins
// RQ16: address past final limit hits no row
module drbd_row_decode #(
   parameter drbd_pkg::drbd_variant_t VARIANT = drbd_pkg::DRBD_VAR_EIGHT // device variant
) (
   input wire logic clk_sys,                             // controller clock, 40 MHz
   input wire logic arst_n,                              // asynchronous reset, active low
   input wire logic [drbd_pkg::BUS_ADDR_W-1:0] reg_addr, // register byte address
   input wire logic [drbd_pkg::REG_W-1:0] reg_wdata,     // register write data
   input wire logic reg_wr,                              // write strobe
   input wire logic reg_rd,                              // read strobe
   output logic [drbd_pkg::REG_W-1:0] reg_rdata,         // read data, cycle after strobe
   input wire logic acc_valid,                           // access request valid
   input wire logic [drbd_pkg::ADDR_W-1:0] acc_addr,     // gap-free controller address
   output logic dec_valid,                               // decode result valid, one cycle
   output logic dec_hit,                                 // access falls into some row
   output logic [2:0] dec_row,                           // selected row number
   output logic [drbd_pkg::MAX_ROWS-1:0] dec_row_sel     // one-hot row select
);
   // derived variant geometry
   localparam int unsigned NROWS =
      (VARIANT == drbd_pkg::DRBD_VAR_EIGHT) ? drbd_pkg::MAX_ROWS : drbd_pkg::ROWS_SMALL; // [RQ1] [RQ2]
   localparam int unsigned LW =
      (VARIANT == drbd_pkg::DRBD_VAR_EIGHT) ? drbd_pkg::LIMIT_W_LARGE
                                            : drbd_pkg::LIMIT_W_SMALL; // [RQ10] [RQ11]
   localparam int unsigned HI_W = drbd_pkg::ADDR_W - drbd_pkg::UNIT_SHIFT - LW; // overflow bits

   // elaboration check: field plus unit shift must leave at least one overflow bit in the address
   if (drbd_pkg::ADDR_W < drbd_pkg::UNIT_SHIFT + LW + 1) begin : g_bad_width
      $error("address width too small for the limit field");
   end

   // reset synchroniser, two stages
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_n;

   // release of reset is synchronised, assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // register address decode
   logic [7:0] rel_off;   // offset from the first limit register
   logic map_hit;         // address falls in the limit block
   logic [2:0] map_idx;   // register index 0..7

   always_comb begin
      rel_off = reg_addr - drbd_pkg::ROW_LIMIT_BASE;
      // all eight registers are mapped on both variants
      map_hit = (reg_addr >= drbd_pkg::ROW_LIMIT_BASE) &&
                (rel_off < 8'(drbd_pkg::MAX_ROWS * drbd_pkg::ROW_LIMIT_STEP)) &&
                !rel_off[0];
      map_idx = rel_off[3:1];
   end

   // limit storage, only the implemented field bits exist
   logic [LW-1:0] limit_q [drbd_pkg::MAX_ROWS];

   // one write port per register, reserved bits are dropped
   genvar gi;
   for (gi = 0; gi < drbd_pkg::MAX_ROWS; gi++) begin : g_limit
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            limit_q[gi] <= LW'(drbd_pkg::ROW_LIMIT_RST); // [RQ8]
         end else if (reg_wr && map_hit && (map_idx == 3'(gi))) begin
            limit_q[gi] <= reg_wdata[LW-1:0]; // [RQ3] [RQ10] [RQ11]
         end
      end
   end

   // read data register, stands only the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd && map_hit) begin
         // reserved upper bits read as zero
         reg_rdata <= drbd_pkg::REG_W'(limit_q[map_idx]); // [RQ10] [RQ11]
      end else begin
         // unmapped reads and idle cycles answer zero
         reg_rdata <= '0;
      end
   end

   // address split into 4 Mbyte units and overflow bits
   logic [LW-1:0] addr_unit;   // unit index within the limit field
   logic addr_over;            // unit index beyond what any limit can express

   always_comb begin
      addr_unit = acc_addr[drbd_pkg::UNIT_SHIFT +: LW]; // [RQ4]
      addr_over = |acc_addr[drbd_pkg::ADDR_W-1 -: HI_W];
   end

   // per-row comparison of address against cumulative upper limits
   logic [drbd_pkg::MAX_ROWS-1:0] below;  // address below limit of row n

   for (gi = 0; gi < drbd_pkg::MAX_ROWS; gi++) begin : g_cmp
      if (gi < NROWS) begin : g_live
         drbd_row_cmp #(
            .LIMIT_W(LW)
         ) u_cmp (
            .limit(limit_q[gi]),
            .addr_unit(addr_unit),
            .addr_over(addr_over),
            .below(below[gi])
         );
      end else begin : g_dead
         // rows beyond the variant never take an access
         assign below[gi] = 1'b0; // [RQ1]
      end
   end

   // priority pick of the lowest row whose limit exceeds the address;
   // a row of zero size is skipped because its lower bound equals its limit
   logic [drbd_pkg::MAX_ROWS-1:0] sel_d;  // one-hot select
   logic [2:0] row_d;                     // encoded row
   logic hit_d;                           // any row taken

   always_comb begin
      sel_d = '0;
      row_d = 3'h0;
      hit_d = 1'b0;
      for (int i = drbd_pkg::MAX_ROWS - 1; i >= 0; i--) begin
         if (below[i]) begin
            sel_d = '0;
            sel_d[i] = 1'b1; // [RQ15] [RQ5] [RQ6]
            row_d = 3'(i);
            hit_d = 1'b1;
         end
      end
      // past the final limit: no row at all
      if (!hit_d) begin
         sel_d = '0; // [RQ16]
      end
   end

   // registered decode result, one cycle after the access
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dec_valid <= 1'b0;
         dec_hit <= 1'b0;
         dec_row <= 3'h0;
         dec_row_sel <= '0;
      end else begin
         dec_valid <= acc_valid;
         dec_hit <= acc_valid && hit_d; // [RQ16]
         dec_row <= acc_valid ? row_d : 3'h0;
         dec_row_sel <= acc_valid ? sel_d : '0; // [RQ15]
      end
   end

   // ---- assertions ----
   // helpers: previous-cycle view of the access and limits
   logic [LW-1:0] lim_prev_row;  // limit of selected row at request time
   always_comb begin
      lim_prev_row = limit_q[row_d];
   end

   sequence s_req;
      acc_valid && !reg_wr;
   endsequence

   a_onehot_select: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ15]
      dec_valid |-> ($onehot0(dec_row_sel) && (dec_hit == (dec_row_sel != '0))))
      else $error("row select not one-hot or hit mismatch");

   a_row_matches_sel: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ15]
      dec_hit |-> dec_row_sel[dec_row])
      else $error("encoded row disagrees with select");

   a_hit_below_limit: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ5]
      s_req ##0 hit_d |=> dec_hit && ($past(addr_unit) < $past(lim_prev_row))
                          && !$past(addr_over))
      else $error("selected row limit not above address");

   a_lower_bound: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ6]
      (s_req ##0 (hit_d && row_d != 3'h0)) |-> !below[row_d - 3'h1])
      else $error("lower row would have taken the access");

   a_miss_no_row: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ16]
      (acc_valid && below == '0) |=> (dec_valid && !dec_hit && dec_row_sel == '0))
      else $error("access past final limit selected a row");

   a_variant_rows: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ1]
      dec_valid |-> (dec_row_sel >> NROWS) == '0)
      else $error("row beyond variant selected");

   a_write_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ3]
      (reg_wr && map_hit) ##1 (reg_rd && map_hit && map_idx == $past(map_idx) && !reg_wr)
      |=> reg_rdata == drbd_pkg::REG_W'($past(reg_wdata[LW-1:0], 2)))
      else $error("limit register does not read back written field");

   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ10]
      (reg_rdata >> LW) == '0)
      else $error("reserved limit bits read nonzero");

   a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ11]
      (reg_rd && !map_hit) |=> reg_rdata == '0)
      else $error("unmapped read returned data");

   a_reset_value: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ8]
      $rose(rst_n) |-> limit_q[0] == LW'(drbd_pkg::ROW_LIMIT_RST))
      else $error("row limit not at reset value");

   // ---- register port, decode and reset checks ----
   // helpers: what the current strobe addresses and whether it is taken
   logic [LW-1:0] rd_view;  // limit that a mapped read returns next cycle
   logic wr_hit;            // mapped write taken on this edge
   logic rd_hit;            // mapped read taken on this edge

   // built from the same nets as the real port, so the checks see what the logic sees
   always_comb begin
      rd_view = limit_q[map_idx];
      wr_hit = reg_wr && map_hit;
      rd_hit = reg_rd && map_hit;
   end

   // a mapped write on this edge
   sequence s_wr_taken;
      wr_hit;
   endsequence

   // a mapped read with no write beside it
   sequence s_rd_taken;
      rd_hit && !reg_wr;
   endsequence

   // an access that lands in some row above row zero
   sequence s_upper_hit;
      acc_valid && hit_d && (row_d != 3'h0);
   endsequence

   // the written field is what the addressed register holds next
   a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ3]
      s_wr_taken |=> limit_q[$past(map_idx)] == $past(reg_wdata[LW-1:0]))
      else $error("written limit not stored");

   // a mapped read answers with the addressed limit, zero extended
   a_read_returns: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ10]
      s_rd_taken |=> reg_rdata == drbd_pkg::REG_W'($past(rd_view)))
      else $error("read data not the addressed limit");

   // read data stands one cycle only, zero otherwise
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ3]
      !rd_hit |=> reg_rdata == '0)
      else $error("read data outside its cycle");

   // only even offsets in the block are taken
   a_even_offset: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ3]
      map_hit |-> !reg_addr[0])
      else $error("odd register offset taken");

   // each limit keeps its value unless its own write comes;
   // per row, so a stray write strobe on a neighbour is caught too
   for (gi = 0; gi < drbd_pkg::MAX_ROWS; gi++) begin : g_hold
      a_limit_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ3]
         !(wr_hit && (map_idx == 3'(gi))) |=> $stable(limit_q[gi]))
         else $error("limit changed without a write");
   end

   // rows outside the variant never signal below
   for (gi = 0; gi < drbd_pkg::MAX_ROWS; gi++) begin : g_dead_chk
      if (gi >= NROWS) begin : g_off
         a_dead_row: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ1]
            !below[gi])
            else $error("row beyond the variant compared live");
      end
   end

   // every access answers exactly one cycle later
   a_valid_follows: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ15]
      acc_valid |=> dec_valid)
      else $error("decode result missing");

   // no access, no result: outputs drop back to zero
   a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ16]
      !acc_valid |=> (!dec_valid && !dec_hit && dec_row == 3'h0 && dec_row_sel == '0))
      else $error("decode outputs not quiet when idle");

   // an address under the first limit always goes to row zero
   a_first_row_wins: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ15]
      (acc_valid && below[0]) |=> (dec_hit && dec_row == 3'h0))
      else $error("row zero passed over");

   // high address bits beyond any limit make a miss
   a_overflow_miss: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ16]
      (acc_valid && addr_over) |=> !dec_hit)
      else $error("overflowing address hit a row");

   // the row number never names a row that the variant lacks
   a_row_in_variant: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ2]
      dec_valid |-> (32'(dec_row) < NROWS))
      else $error("row number beyond variant");

   // a miss reports row zero, never a stale row number
   a_miss_row_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ16]
      (dec_valid && !dec_hit) |-> (dec_row == 3'h0))
      else $error("miss carried a row number");

   // select line and row number agree exactly
   a_sel_is_row: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ15]
      dec_hit |-> (dec_row_sel == (8'h01 << dec_row)))
      else $error("select does not match row number");

   // a winning row above zero has nonzero size: equal limits never win
   a_zero_size_skip: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ6]
      s_upper_hit |-> (limit_q[row_d] != limit_q[row_d - 3'h1]))
      else $error("row of zero size took an access");

   // the address sits at or above the lower bound of the winning row
   a_above_lower: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ5]
      s_upper_hit |-> (addr_over || !(addr_unit < limit_q[row_d - 3'h1])))
      else $error("address under the lower bound of its row");

   // release walks through both stages in order; arst_n disables here
   // because the checked flops are the ones that make rst_n
   a_sync_stages: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ8]
      rst_s1_q |=> rst_s2_q)
      else $error("reset synchroniser skipped a stage");

   // after release the last live row starts from its default limit too
   a_reset_all: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ8]
      $rose(rst_n) |-> (limit_q[NROWS-1] == LW'(drbd_pkg::ROW_LIMIT_RST)))
      else $error("last row limit not at reset value");

endmodule : drbd_row_decode
